// ---- lio_pkg.sv ----
// Constants, types and helpers for the long-integer load, OR, set and
// read-back instruction group.
// Assumes one system clock and a byte-wide command stream from the host.
//
// Contract
// - Unsigned byte load zero-extends into scratch register.
// - Argument mode stores into next argument register.
// - Unsigned word load zero-extends into scratch register.
// - Signed word load sign-extends into scratch register.
// - One operand byte selects any register 0-255.
// - Register OR merges named register into working.
// - Operand converted to working register width first.
// - Immediate OR merges zero-extended byte into working.
// - Named register read returns four bytes.
// - Read results leave most significant byte first.
// - Wide source truncated to 32 bits for reads.
// - Working register read returns four bytes.
// - Low byte read returns one byte.
// - Low word read returns two bytes, high first.
// - Indexed read returns register, then pointer advances.
// - Scratch read picks register by working width.
// - Set copies named register into working register.
// - Set immediate sign-extends byte into working register.
// - Set from scratch copies scratch into working.
// - Status: bit 1 negative, bit 0 zero.
package lio_pkg;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_LOAD_UBYTE  = 8'hC7;
  localparam logic [7:0] OP_LOAD_UWORD  = 8'hC9;
  localparam logic [7:0] OP_LOAD_SWORD  = 8'hC8;
  localparam logic [7:0] OP_OR_REG      = 8'hC1;
  localparam logic [7:0] OP_OR_IMM      = 8'hCC;
  localparam logic [7:0] OP_READ_NAMED  = 8'h94;
  localparam logic [7:0] OP_READ_WORK   = 8'h95;
  localparam logic [7:0] OP_READ_INDEX  = 8'h96;
  localparam logic [7:0] OP_READ_SCR    = 8'h97;
  localparam logic [7:0] OP_READ_BYTE   = 8'h98;
  localparam logic [7:0] OP_READ_WORD   = 8'h99;
  localparam logic [7:0] OP_SET_REG     = 8'h9C;
  localparam logic [7:0] OP_SET_IMM     = 8'hAE;
  localparam logic [7:0] OP_SET_SCR     = 8'hA5;

  // ----------------------------------------------------------------------
  // Register numbering and status layout
  // ----------------------------------------------------------------------
  localparam int         WIDE_BIT       = 7;      // Set for 64-bit registers.
  localparam logic [7:0] SCRATCH_NARROW = 8'h00;
  localparam logic [7:0] SCRATCH_WIDE   = 8'h80;
  localparam logic [7:0] LAST_NARROW    = 8'h7F;
  localparam logic [7:0] LAST_WIDE      = 8'hFF;
  localparam logic [3:0] ARG_SLOTS      = 4'h9;   // Argument registers 1 to 9.
  localparam int         ST_SIGN        = 1;
  localparam int         ST_ZERO        = 0;
  localparam logic [1:0] STATUS_RESET   = 2'h0;
  localparam logic [2:0] BYTES_LONG     = 3'h4;
  localparam logic [2:0] BYTES_WORD     = 3'h2;
  localparam logic [2:0] BYTES_BYTE     = 3'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_OPCODE, ST_OPERAND, ST_EXEC, ST_SEND} lio_state_t;

  // One write into the register bank.
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [63:0] data;
  } lio_wr_t;

  // One byte of read-back data towards the host.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } lio_rd_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Number of operand bytes following an opcode of this group.
  function automatic logic [1:0] operand_count(input logic [7:0] op);
    case (op)
      OP_LOAD_UWORD, OP_LOAD_SWORD: operand_count = 2'h2;
      OP_LOAD_UBYTE, OP_OR_REG, OP_OR_IMM, OP_READ_NAMED,
      OP_SET_REG, OP_SET_IMM: operand_count = 2'h1;
      default: operand_count = 2'h0;
    endcase
  endfunction

  // Long-integer status of a value seen at the given register width.
  function automatic logic [1:0] long_status(input logic [63:0] v, input logic wide);
    logic [1:0] s;
    s = STATUS_RESET;
    s[ST_SIGN] = wide ? v[63] : v[31];
    s[ST_ZERO] = wide ? (v == 64'h0) : (v[31:0] == 32'h0);
    long_status = s;
  endfunction

endpackage

// ---- lio_reg_bank.sv ----
// Register bank of 128 narrow and 128 wide long-integer registers.
// Assumes the caller presents at most one write per cycle.
`timescale 1ns/1ps
module lio_reg_bank (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Write port
  input  wire lio_pkg::lio_wr_t wr,
  // Read ports, values widened to 64 bits
  input  wire logic [7:0]      raddr_p,
  output logic      [63:0]     rdata_p,
  input  wire logic [7:0]      raddr_q,
  output logic      [63:0]     rdata_q
);

  logic [31:0] narrow_q [128];
  logic [63:0] wide_q   [128];

  // Widen a register to 64 bits; narrow ones sign-extend.
  function automatic logic [63:0] fetch(input logic [7:0] a);
    if (a[lio_pkg::WIDE_BIT]) begin
      fetch = wide_q[a[6:0]];
    end else begin
      fetch = {{32{narrow_q[a[6:0]][31]}}, narrow_q[a[6:0]]};
    end
  endfunction

  // Registers clear at reset; narrow writes keep the low 32 bits.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        narrow_q[i] <= 32'h0;
        wide_q[i]   <= 64'h0;
      end
    end else if (wr.en) begin
      if (wr.addr[lio_pkg::WIDE_BIT]) begin
        wide_q[wr.addr[6:0]] <= wr.data;
      end else begin
        narrow_q[wr.addr[6:0]] <= wr.data[31:0];
      end
    end
  end

  // Two combinational read ports. A process also wakes on a write into the
  // bank, so a read right after a write sees the new value.
  always_comb begin
    rdata_p = fetch(raddr_p);
    rdata_q = fetch(raddr_q);
  end

endmodule

// ---- lio_exec.sv ----
// Decoder and executor for the long-integer load, OR, set and read-back
// instruction group.
// Assumes opcode and operand bytes arrive one per handshake from the
// command link, and the host drains read bytes before the next opcode.
`timescale 1ns/1ps
module lio_exec (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Command bytes from the host
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  output logic             cmd_ready,
  // Read-back bytes to the host
  output logic             rd_valid,
  output logic [7:0]       rd_byte,
  input  wire logic        rd_take,
  // Context kept by neighbouring instruction groups
  input  wire logic [7:0]  work_sel,
  input  wire logic        arg_mode,
  input  wire logic        arg_restart,
  input  wire logic        index_load,
  input  wire logic [7:0]  index_value,
  // Status and state
  output logic [1:0]       long_status_q,
  output logic [7:0]       index_q,
  output logic             busy
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Reset asserts at once and releases two edges later.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  lio_pkg::lio_state_t state_q;
  logic [7:0]  opcode_q;
  logic [7:0]  opnd0_q;
  logic [7:0]  opnd1_q;
  logic [1:0]  need_q;
  logic [3:0]  arg_cnt_q;
  logic [31:0] send_q;
  logic [2:0]  left_q;
  logic [1:0]  status_q;
  logic [7:0]  index_reg_q;

  // Decode results for the instruction in execution.
  lio_pkg::lio_wr_t wr;
  logic [7:0]  src_addr;
  logic [63:0] src_val;
  logic [63:0] work_val;
  logic        work_wide;
  logic [7:0]  scratch;
  logic [7:0]  load_dest;
  logic        is_load;
  logic        is_read;
  logic [31:0] send_word;
  logic [2:0]  send_len;
  logic        index_step;

  assign work_wide = work_sel[lio_pkg::WIDE_BIT];
  assign scratch   = work_wide ? lio_pkg::SCRATCH_WIDE : lio_pkg::SCRATCH_NARROW;

  // ----------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------
  lio_reg_bank u_bank (
    .clk     (core_clk),
    .rst_n   (rst_n),
    .wr      (wr),
    .raddr_p (src_addr),
    .rdata_p (src_val),
    .raddr_q (work_sel),
    .rdata_q (work_val)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Destination of a load, honouring argument-list mode.
  function automatic logic [7:0] load_target(input logic [7:0] base,
                                             input logic       args,
                                             input logic [3:0] cnt);
    if (args) begin
      load_target = base + 8'h01 + {4'h0, cnt};
    end else begin
      load_target = base;
    end
  endfunction

  // Next value of the index pointer, held at the end of its bank.
  function automatic logic [7:0] index_next(input logic [7:0] x);
    logic [7:0] last;
    last = x[lio_pkg::WIDE_BIT] ? lio_pkg::LAST_WIDE : lio_pkg::LAST_NARROW;
    index_next = (x == last) ? x : x + 8'h01;
  endfunction

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // Pick the register that feeds an OR, a set or a read.
  always_comb begin
    case (opcode_q)
      lio_pkg::OP_OR_REG,
      lio_pkg::OP_SET_REG,
      lio_pkg::OP_READ_NAMED: src_addr = opnd0_q;
      lio_pkg::OP_READ_INDEX: src_addr = index_reg_q;
      lio_pkg::OP_READ_SCR,
      lio_pkg::OP_SET_SCR:    src_addr = scratch;
      default:                src_addr = work_sel;
    endcase
  end

  assign load_dest = load_target(scratch, arg_mode, arg_cnt_q);

  // ----------------------------------------------------------------------
  // Execution decode
  // ----------------------------------------------------------------------
  // Form the register write and the read-back word of the current opcode.
  always_comb begin
    wr         = '0;
    is_load    = 1'b0;
    is_read    = 1'b0;
    send_word  = 32'h0;
    send_len   = lio_pkg::BYTES_LONG;
    index_step = 1'b0;
    case (opcode_q)
      lio_pkg::OP_LOAD_UBYTE: begin
        is_load = 1'b1;
        wr.data = {56'h0, opnd0_q};
      end
      lio_pkg::OP_LOAD_UWORD: begin
        is_load = 1'b1;
        wr.data = {48'h0, opnd0_q, opnd1_q};
      end
      lio_pkg::OP_LOAD_SWORD: begin
        is_load = 1'b1;
        wr.data = {{48{opnd0_q[7]}}, opnd0_q, opnd1_q};
      end
      lio_pkg::OP_OR_REG: begin
        wr.en   = 1'b1;
        wr.data = work_val | src_val;
      end
      lio_pkg::OP_OR_IMM: begin
        wr.en   = 1'b1;
        wr.data = work_val | {56'h0, opnd0_q};
      end
      lio_pkg::OP_SET_REG: begin
        wr.en   = 1'b1;
        wr.data = src_val;
      end
      lio_pkg::OP_SET_IMM: begin
        wr.en   = 1'b1;
        wr.data = {{56{opnd0_q[7]}}, opnd0_q};
      end
      lio_pkg::OP_SET_SCR: begin
        wr.en   = 1'b1;
        wr.data = src_val;
      end
      lio_pkg::OP_READ_NAMED: begin
        is_read   = 1'b1;
        send_word = src_val[31:0];
      end
      lio_pkg::OP_READ_WORK: begin
        is_read   = 1'b1;
        send_word = work_val[31:0];
      end
      lio_pkg::OP_READ_INDEX: begin
        is_read    = 1'b1;
        send_word  = src_val[31:0];
        index_step = 1'b1;
      end
      lio_pkg::OP_READ_SCR: begin
        is_read   = 1'b1;
        send_word = src_val[31:0];
      end
      lio_pkg::OP_READ_BYTE: begin
        is_read   = 1'b1;
        send_word = {work_val[7:0], 24'h0};
        send_len  = lio_pkg::BYTES_BYTE;
      end
      lio_pkg::OP_READ_WORD: begin
        is_read   = 1'b1;
        send_word = {work_val[15:0], 16'h0};
        send_len  = lio_pkg::BYTES_WORD;
      end
      default: begin
        wr.data = 64'h0;
      end
    endcase
    if (state_q != lio_pkg::ST_EXEC) begin
      wr.en      = 1'b0;
      is_load    = 1'b0;
      is_read    = 1'b0;
      index_step = 1'b0;
    end
    if (is_load) begin
      wr.en = 1'b1;
    end
    wr.addr = is_load ? load_dest : work_sel;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Collect opcode and operands, execute once, then send any result.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= lio_pkg::ST_OPCODE;
      opcode_q <= 8'h00;
      opnd0_q  <= 8'h00;
      opnd1_q  <= 8'h00;
      need_q   <= 2'h0;
    end else begin
      case (state_q)
        lio_pkg::ST_OPCODE: begin
          if (cmd_valid) begin
            opcode_q <= cmd_byte;
            need_q   <= lio_pkg::operand_count(cmd_byte);
            if (lio_pkg::operand_count(cmd_byte) == 2'h0) begin
              state_q <= lio_pkg::ST_EXEC;
            end else begin
              state_q <= lio_pkg::ST_OPERAND;
            end
          end
        end
        lio_pkg::ST_OPERAND: begin
          if (cmd_valid) begin
            opnd0_q <= opnd1_q;
            opnd1_q <= cmd_byte;
            need_q  <= need_q - 2'h1;
            if (need_q == 2'h1) begin
              state_q <= lio_pkg::ST_EXEC;
            end
            if (need_q == 2'h1 && lio_pkg::operand_count(opcode_q) == 2'h1) begin
              opnd0_q <= cmd_byte;
            end
          end
        end
        lio_pkg::ST_EXEC: begin
          state_q <= is_read ? lio_pkg::ST_SEND : lio_pkg::ST_OPCODE;
        end
        lio_pkg::ST_SEND: begin
          if (rd_take && left_q == 3'h1) begin
            state_q <= lio_pkg::ST_OPCODE;
          end
        end
        default: begin
          state_q <= lio_pkg::ST_OPCODE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read-back shifter
  // ----------------------------------------------------------------------
  // Load the result, then shift one byte out per host take.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      send_q <= 32'h0;
      left_q <= 3'h0;
    end else if (is_read) begin
      send_q <= send_word;
      left_q <= send_len;
    end else if (state_q == lio_pkg::ST_SEND && rd_take) begin
      send_q <= {send_q[23:0], 8'h00};
      left_q <= left_q - 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  // Every write of this group refreshes sign and zero from the stored value.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= lio_pkg::STATUS_RESET;
    end else if (wr.en) begin
      status_q <= lio_pkg::long_status(wr.data, wr.addr[lio_pkg::WIDE_BIT]);
    end
  end

  // ----------------------------------------------------------------------
  // Argument counter
  // ----------------------------------------------------------------------
  // Steps through the argument registers, holding at the last one.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arg_cnt_q <= 4'h0;
    end else if (arg_restart) begin
      arg_cnt_q <= 4'h0;
    end else if (is_load && arg_mode && arg_cnt_q != lio_pkg::ARG_SLOTS - 4'h1) begin
      arg_cnt_q <= arg_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Index pointer
  // ----------------------------------------------------------------------
  // A neighbour load wins over the step taken by an indexed read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg_q <= 8'h00;
    end else if (index_load) begin
      index_reg_q <= index_value;
    end else if (index_step) begin
      index_reg_q <= index_next(index_reg_q);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Handshakes are combinational; data comes from flip-flops.
  assign cmd_ready     = (state_q == lio_pkg::ST_OPCODE) || (state_q == lio_pkg::ST_OPERAND);
  assign rd_valid      = (state_q == lio_pkg::ST_SEND);
  assign rd_byte       = send_q[31:24];
  assign long_status_q = status_q;
  assign index_q       = index_reg_q;
  assign busy          = (state_q != lio_pkg::ST_OPCODE);

endmodule

// ---- lio_exec_assertions.sv ----
// Port checker for the long-integer load, OR, set and read-back executor.
// Assumes one clock; bound to every executor instance at the foot of this file.
`timescale 1ns/1ps
module lio_exec_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Command link
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_ready,
  // Read link and state
  input wire logic       rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_take,
  input wire logic [1:0] long_status_q,
  input wire logic       busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  // An opcode taken while the executor waits for one, an operand, a read take.
  sequence s_op(logic [7:0] op);
    cmd_valid && cmd_ready && !busy && cmd_byte == op;
  endsequence
  sequence s_arg;
    cmd_valid && cmd_ready && busy;
  endsequence
  sequence s_take;
    rd_valid && rd_take;
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  ready_excl_a: assert property (rd_valid |-> !cmd_ready)
    else $error("command link open while read bytes remain");
  byte_hold_a: assert property (rd_valid && !rd_take |=> rd_valid && $stable(rd_byte))
    else $error("read byte moved before it was taken");
  ubyte_status_a: assert property (s_op(8'hC7) ##1 s_arg |-> ##2
    long_status_q == {1'b0, $past(cmd_byte, 2) == 8'h00}) else $error("byte load status");
  uword_status_a: assert property (s_op(8'hC9) ##1 s_arg [*2] |-> ##2
    long_status_q == {1'b0, {$past(cmd_byte, 3), $past(cmd_byte, 2)} == 16'h0000})
    else $error("unsigned word load status");
  sword_status_a: assert property (s_op(8'hC8) ##1 s_arg [*2] |-> ##2
    long_status_q == {$past(cmd_byte[7], 3), {$past(cmd_byte, 3), $past(cmd_byte, 2)} == 16'h0000})
    else $error("signed word load status");
  seti_status_a: assert property (s_op(8'hAE) ##1 s_arg |-> ##2
    long_status_q == {$past(cmd_byte[7], 2), $past(cmd_byte, 2) == 8'h00})
    else $error("immediate set status");
  scratch_start_a: assert property (s_op(8'h97) |-> ##2 rd_valid)
    else $error("scratch read did not start");
  byte_count_a: assert property (s_op(8'h98) ##2 s_take |=> !rd_valid)
    else $error("low byte read length");
  word_count_a: assert property (s_op(8'h99) ##2 s_take [*2] |=> !rd_valid)
    else $error("low word read length");
  long_count_a: assert property (s_op(8'h95) ##2 s_take [*4] |=> !rd_valid)
    else $error("working read length");
endmodule

bind lio_exec lio_exec_chk u_chk (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_byte(rd_byte),
  .rd_take(rd_take), .long_status_q(long_status_q), .busy(busy));

// ---- lio_host_model.sv ----
// Host model: sends instruction bytes and collects read-back bytes.
// Assumes the caller lets the executor settle between instructions.
`timescale 1ns/1ps
module lio_host_model (
  // Clock
  input wire logic       core_clk,
  // Command link
  output logic           cmd_valid,
  output logic     [7:0] cmd_byte,
  input wire logic       cmd_ready,
  input wire logic       busy,
  // Read link
  input wire logic       rd_valid,
  input wire logic [7:0] rd_byte,
  output logic           rd_take
);
  // Idle link levels at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    rd_take   = 1'b0;
  end
  // Sends all bytes of one instruction back to back, each held until taken.
  task automatic send(input logic [7:0] b [$], output logic ok);
    int i;
    int t;
    ok = 1'b1;
    for (i = 0; i < b.size(); i++) begin
      cmd_valid <= 1'b1;
      cmd_byte  <= b[i];
      t = 0;
      do begin @(posedge core_clk); t++; end while (cmd_ready !== 1'b1 && t < 50);
      if (cmd_ready !== 1'b1) ok = 1'b0;
    end
    cmd_valid <= 1'b0;
    cmd_byte  <= ~b[b.size()-1]; // A released line must not show the last byte.
  endtask
  // Waits until the executor reports ready with nothing pending.
  task automatic settle(output logic ok);
    int t;
    t = 0;
    do begin @(posedge core_clk); t++; end while ((busy !== 1'b0 || cmd_ready !== 1'b1) && t < 50);
    ok = (busy === 1'b0);
  endtask
  // Drains n result bytes at once, taking each or every other cycle.
  task automatic collect(input int n, input logic slow, output logic [31:0] v,
                         output logic ok);
    int k;
    int t;
    k = 0;
    t = 0;
    v = 32'h0;
    rd_take <= !slow;
    while (k < n && t < 60) begin
      @(posedge core_clk);
      t++;
      if (rd_take && rd_valid === 1'b1) begin v = {v[23:0], rd_byte}; k++; end
      rd_take <= (k < n) && (slow ? (!rd_take && rd_valid === 1'b1) : 1'b1);
    end
    ok = (k == n);
  endtask
endmodule

// ---- long_int_load_or_read_set_ops_test.sv ----
// Self-checking bench for the long-integer load, OR, set and read-back executor.
// Assumes the host model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
module long_int_load_or_read_set_ops_test;
  logic core_clk, nrst, cmd_valid, cmd_ready, rd_valid, rd_take, busy;
  logic arg_mode, arg_restart, index_load;
  logic [7:0] cmd_byte, rd_byte, work_sel, index_value, index_q;
  logic [1:0] long_status_q;
  int         fails, samples_checked;
  lio_exec dut (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_take(rd_take),
    .work_sel(work_sel), .arg_mode(arg_mode), .arg_restart(arg_restart),
    .index_load(index_load), .index_value(index_value), .long_status_q(long_status_q),
    .index_q(index_q), .busy(busy));
  lio_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .busy(busy), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .rd_take(rd_take));
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Compares one seen value with its expectation and counts the result.
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Checked %0d values, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Issues one write instruction and waits for the executor to settle.
  task automatic wr(input logic [7:0] b [$]);
    logic ok;
    host.send(b, ok);
    if (ok === 1'b1) host.settle(ok);
    if (ok !== 1'b1) begin fails++; end_sim(); end
  endtask
  // Issues one read instruction and compares the assembled result.
  task automatic rd(input logic [7:0] b [$], input int n, input logic slow,
                    input logic [31:0] exp, input string what);
    logic ok;
    logic [31:0] v;
    host.send(b, ok);
    if (ok === 1'b1) host.collect(n, slow, v, ok);
    if (ok === 1'b1) host.settle(ok);
    if (ok !== 1'b1) begin fails++; end_sim(); end
    check(what, v, exp);
  endtask
  // Selects the working register between instructions.
  task automatic sel(input logic [7:0] r);
    @(posedge core_clk);
    work_sel <= r;
  endtask
  // Loads into the scratch register at both widths.
  task automatic t_loads();
    sel(8'h05);
    wr('{8'hC7, 8'h85});
    rd('{8'h97}, 4, 1'b0, 32'h0000_0085, "byte load");
    wr('{8'hC9, 8'h80, 8'h01});
    rd('{8'h97}, 4, 1'b0, 32'h0000_8001, "unsigned word load");
    wr('{8'hC8, 8'h80, 8'h01});
    check("signed word status", {30'h0, long_status_q}, 32'h2);
    rd('{8'h97}, 4, 1'b0, 32'hFFFF_8001, "signed word load");
    sel(8'h85);
    wr('{8'hC7, 8'h00});
    check("zero load status", {30'h0, long_status_q}, 32'h1);
    wr('{8'h00});
    check("foreign opcode status", {30'h0, long_status_q}, 32'h1);
    wr('{8'hC8, 8'hFF, 8'hFE});
    rd('{8'h97}, 4, 1'b1, 32'hFFFF_FFFE, "wide scratch read");
  endtask
  // Sets, ORs and reads the working register.
  task automatic t_set_or();
    sel(8'h05);
    wr('{8'hC7, 8'h85});
    wr('{8'hA5});
    rd('{8'h95}, 4, 1'b0, 32'h0000_0085, "set from scratch");
    wr('{8'hCC, 8'h30});
    rd('{8'h98}, 1, 1'b0, 32'h0000_00B5, "immediate or");
    wr('{8'h9C, 8'h80});
    check("set status", {30'h0, long_status_q}, 32'h2);
    rd('{8'h99}, 2, 1'b0, 32'h0000_FFFE, "set from wide");
    wr('{8'hAE, 8'h00});
    wr('{8'hC1, 8'h00});
    rd('{8'h94, 8'h05}, 4, 1'b1, 32'h0000_0085, "register or");
    sel(8'h81);
    wr('{8'hAE, 8'h80});
    rd('{8'h95}, 4, 1'b0, 32'hFFFF_FF80, "wide immediate set");
    wr('{8'hC1, 8'h00});
    rd('{8'h95}, 4, 1'b0, 32'hFFFF_FF85, "wide or of narrow");
  endtask
  // Argument-list loads, then indexed reads with pointer advance.
  task automatic t_args_index();
    sel(8'h05);
    arg_mode    <= 1'b1;
    arg_restart <= 1'b1;
    index_load  <= 1'b1;
    index_value <= 8'h01;
    @(posedge core_clk);
    arg_restart <= 1'b0;
    index_load  <= 1'b0;
    wr('{8'hC7, 8'h11});
    wr('{8'hC9, 8'h00, 8'h22});
    @(posedge core_clk);
    arg_mode <= 1'b0;
    rd('{8'h94, 8'h01}, 4, 1'b1, 32'h0000_0011, "first argument");
    rd('{8'h97}, 4, 1'b0, 32'h0000_0085, "scratch kept");
    rd('{8'h94, 8'hFF}, 4, 1'b1, 32'h0000_0000, "last register");
    rd('{8'h96}, 4, 1'b0, 32'h0000_0011, "indexed first");
    rd('{8'h96}, 4, 1'b1, 32'h0000_0022, "indexed second");
    check("index pointer", {24'h0, index_q}, 32'h3);
  endtask
  // Reset in mid-run clears the pointer and the bank.
  task automatic t_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("reset pointer", {24'h0, index_q}, 32'h0);
    rd('{8'h97}, 4, 1'b0, 32'h0000_0000, "reset scratch");
  endtask
  // Reset, the scenarios, then the verdict.
  initial begin
    fails = 0;
    samples_checked = 0;
    nrst = 1'b0;
    work_sel = 8'h05;
    arg_mode = 1'b0;
    arg_restart = 1'b0;
    index_load = 1'b0;
    index_value = 8'h00;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_loads();
    t_set_or();
    t_args_index();
    t_reset();
    end_sim();
  end
endmodule
